// [hdl/led_bank_pkg.sv]
// Shared constants and types for the LED driver register bank and its bus master
package led_bank_pkg;
  localparam int NUM_CH = 36;                           // LED channels
  localparam logic [4:0] ADDR_FIXED = 5'h0F;            // Upper five address bits, 01111
  localparam logic [1:0] STRAP_GND = 2'h0;              // Strap tied low
  localparam logic [1:0] STRAP_SCL = 2'h1;              // Strap tied to clock line
  localparam logic [1:0] STRAP_SDA = 2'h2;              // Strap tied to data line
  localparam logic [1:0] STRAP_VCC = 2'h3;              // Strap tied high
  localparam logic [7:0] OFS_SHUTDOWN = 8'h00;          // soft_shutdown_ctrl
  localparam logic [7:0] OFS_BRIGHT_FIRST = 8'h01;      // channel_brightness first
  localparam logic [7:0] OFS_BRIGHT_LAST = 8'h24;       // channel_brightness last
  localparam logic [7:0] OFS_UPDATE = 8'h25;            // shadow_update_strobe
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h26;        // channel_enable_scale first
  localparam logic [7:0] OFS_CTRL_LAST = 8'h49;         // channel_enable_scale last
  localparam logic [7:0] OFS_GLOBAL = 8'h4A;            // all_leds_disable
  localparam logic [7:0] OFS_RESET = 8'h4F;             // bank_soft_reset
  localparam logic [7:0] MAGIC_ZERO = 8'h00;            // Trigger value for update and reset
  localparam logic [7:0] RESET_BYTE = 8'h00;            // Default of every register
  localparam int BIT_ON = 0;                            // Channel on bit position
  localparam int SCALE_LSB = 1;                         // current_scale_sel low bit position
  localparam int SCL_MAX_KHZ = 400;                     // Fastest legal bus clock
  localparam int MCLK_MHZ = 50;                         // System clock rate
  localparam int HALF_CYC = (MCLK_MHZ * 1000 + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ);  // Cycles per half bit
  localparam int SYNC_CYC = 3;                          // Pipeline depth of sampled bus lines
  // Master orders
  typedef enum logic [1:0] {CMD_NONE = 2'h0, CMD_START = 2'h1, CMD_BYTE = 2'h3, CMD_STOP = 2'h2} cmd_t;
endpackage

// [hdl/led_bus_if.sv]
// Two-wire bus joining the register bank and its master
`timescale 1ns/10ps
interface led_bus_if;
  logic sclOut;   // Master clock drive
  logic sclOe;    // Master clock enable
  logic sdaMOut;  // Master data drive
  logic sdaMOe;   // Master data enable
  logic sdaSOut;  // Bank data drive
  logic sdaSOe;   // Bank data enable
  logic adStrap;  // Strap level, tied low by the bench and not read by the bank
  wire sclLine = ~(sclOe & ~sclOut);                    // Pulled-up clock wire
  wire sdaLine = ~((sdaMOe & ~sdaMOut) | (sdaSOe & ~sdaSOut));  // Pulled-up data wire
  modport device (input sclLine, input sdaLine, output sdaSOut, output sdaSOe);
  modport host (input sclLine, input sdaLine, output sclOut, output sclOe, output sdaMOut, output sdaMOe);
endinterface

// [hdl/line_sync.sv]
// Two-flop synchroniser with one extra stage for edge detection
`timescale 1ns/10ps
module line_sync
  import led_bank_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Async level in, synced level and previous value out
  input wire logic din,
  output logic dout,
  output logic dprev
);
  // Stage flops; first read only by second
  typedef struct packed {logic s1; logic s2; logic s3;} sync_t;
  sync_t st_ff, nxt_st;
  // Shift
  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end
  // Idle bus is high
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout = st_ff.s2;
  assign dprev = st_ff.s3;
endmodule

// [hdl/led_bank_dev.sv]
// Write-only two-wire slave with the shadowed LED register bank
// Notes on behaviour
// - Answer only 01111,strap,write address
// - Strap gnd 00, vcc 11, scl 01, sda 10
// - Master clock at most 400kHz
// - Data sampled while clock high
// - Start: data falls, clock high
// - Stop: data rises, clock high; idle
// - Address byte sent MSB first
// - Hold data low whole ninth pulse
// - Master stops on missing acknowledge
// - Register address byte follows, acknowledged
// - Data bytes MSB first, each acknowledged
// - Pointer increments per data byte
// - Offset 00h bit0: 0 shutdown, reset 0
// - 36 brightness registers 01h-24h, reset 0
// - Shadows load on 00h write to 25h
// - Control bit0 on/off at 26h-49h
// - Control bits 2:1 scale current
// - 4Ah bit0 forces all LEDs off
// - 00h to 4Fh resets whole bank
// - Power-up loads defaults, LEDs dark
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
module led_bank_dev
  import led_bank_pkg::*;
#(
  parameter int CHANNELS = NUM_CH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bus
  led_bus_if.device bus,
  // Strap as seen on the address pin: 0 gnd, 1 vcc, 2 scl, 3 sda
  input wire logic [1:0] strapSel,
  // LED outputs
  output logic [CHANNELS-1:0] ledOn,
  output logic [CHANNELS*2-1:0] currentScaleSel,
  output logic softShutdownN
);
  // Bus phase
  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ADDR = 2'h1, ST_REG = 2'h3, ST_DATA = 2'h2} phase_t;
  typedef struct packed {
    phase_t phase;                   // Which byte is arriving
    logic [3:0] bitCnt;              // Bits taken in current byte, 9 means ack slot
    logic [7:0] shift;               // Incoming byte
    logic ackDrive;                  // Pulling data low
    logic ackMine;                   // Current byte is acknowledged
    logic [7:0] ptr;                 // Register pointer
    logic [1:0] strapVal;            // Captured strap bits
    logic strapDone;                 // Strap captured after reset
    logic shutdownN;                 // soft_shutdown_ctrl bit
    logic allOff;                    // all_leds_disable bit
    logic [CHANNELS-1:0][7:0] brShadow;   // Staged brightness
    logic [CHANNELS-1:0][7:0] brActive;   // Live brightness
    logic [CHANNELS-1:0][2:0] ctShadow;   // Staged control
    logic [CHANNELS-1:0][2:0] ctActive;   // Live control
    logic [7:0] pwmCnt;              // Free-running PWM counter
    logic [CHANNELS-1:0] led;        // Registered LED drive
  } dev_t;
  dev_t st_ff, nxt_st;
  logic scl, sclPrev, sda, sdaPrev;  // Synced lines
  logic sclRise, sclFall, startSeen, stopSeen;
  logic [7:0] wrData;                // Completed byte
  // Line synchronisers
  line_sync u_scl (.mclk(mclk), .rstn(rstn), .din(bus.sclLine), .dout(scl), .dprev(sclPrev));
  line_sync u_sda (.mclk(mclk), .rstn(rstn), .din(bus.sdaLine), .dout(sda), .dprev(sdaPrev));
  // Bus events
  assign sclRise = scl & ~sclPrev;
  assign sclFall = ~scl & sclPrev;
  assign startSeen = scl & sclPrev & sdaPrev & ~sda;
  assign stopSeen = scl & sclPrev & ~sdaPrev & sda;
  assign wrData = st_ff.shift;
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.pwmCnt = st_ff.pwmCnt + 8'h01;
    // Strap caught once after release
    if (!st_ff.strapDone) begin
      nxt_st.strapDone = 1'b1;
      unique case (strapSel)
        2'h0: nxt_st.strapVal = STRAP_GND;
        2'h1: nxt_st.strapVal = STRAP_VCC;
        2'h2: nxt_st.strapVal = STRAP_SCL;
        default: nxt_st.strapVal = STRAP_SDA;
      endcase
    end
    if (startSeen) begin
      // Start or repeated start
      nxt_st.phase = ST_ADDR;
      nxt_st.bitCnt = 4'h0;
      nxt_st.ackDrive = 1'b0;
    end else if (stopSeen) begin
      nxt_st.phase = ST_IDLE;
      nxt_st.ackDrive = 1'b0;
    end else if (st_ff.phase != ST_IDLE && sclRise && st_ff.bitCnt < 4'h8) begin
      // Sample on high clock, MSB first
      nxt_st.shift = {st_ff.shift[6:0], sda};
      nxt_st.bitCnt = st_ff.bitCnt + 4'h1;
    end else if (st_ff.phase != ST_IDLE && sclFall && st_ff.bitCnt == 4'h8 && !st_ff.ackDrive) begin
      // Byte complete: decide and act
      nxt_st.ackMine = 1'b1;
      unique case (st_ff.phase)
        ST_ADDR: begin
          nxt_st.ackMine = (wrData == {ADDR_FIXED, st_ff.strapVal, 1'b0});
          nxt_st.phase = (wrData == {ADDR_FIXED, st_ff.strapVal, 1'b0}) ? ST_REG : ST_IDLE;
        end
        ST_REG: begin
          nxt_st.ptr = wrData;
          nxt_st.phase = ST_DATA;
        end
        default: begin
          // Register write, allowed also in shutdown
          if (st_ff.ptr == OFS_SHUTDOWN) begin
            nxt_st.shutdownN = wrData[0];
          end else if (st_ff.ptr >= OFS_BRIGHT_FIRST && st_ff.ptr <= OFS_BRIGHT_LAST) begin
            nxt_st.brShadow[6'(st_ff.ptr - OFS_BRIGHT_FIRST)] = wrData;
          end else if (st_ff.ptr == OFS_UPDATE && wrData == MAGIC_ZERO) begin
            nxt_st.brActive = st_ff.brShadow;
            nxt_st.ctActive = st_ff.ctShadow;
          end else if (st_ff.ptr >= OFS_CTRL_FIRST && st_ff.ptr <= OFS_CTRL_LAST) begin
            nxt_st.ctShadow[6'(st_ff.ptr - OFS_CTRL_FIRST)] = wrData[2:0];
          end else if (st_ff.ptr == OFS_GLOBAL) begin
            nxt_st.allOff = wrData[0];
          end else if (st_ff.ptr == OFS_RESET && wrData == MAGIC_ZERO) begin
            // Every bank register back to default
            nxt_st.shutdownN = 1'b0;
            nxt_st.allOff = 1'b0;
            nxt_st.brShadow = '0;
            nxt_st.brActive = '0;
            nxt_st.ctShadow = '0;
            nxt_st.ctActive = '0;
          end
          nxt_st.ptr = st_ff.ptr + 8'h01;
        end
      endcase
      nxt_st.ackDrive = nxt_st.ackMine;
      nxt_st.bitCnt = 4'h9;
    end else if (sclFall && st_ff.bitCnt == 4'h9) begin
      // Ninth pulse over: release and start next byte
      nxt_st.ackDrive = 1'b0;
      nxt_st.bitCnt = 4'h0;
    end
    // LED drive: enable, global off, shutdown, PWM compare
    for (int i = 0; i < CHANNELS; i++) begin
      nxt_st.led[i] = st_ff.ctActive[i][BIT_ON] & ~st_ff.allOff & st_ff.shutdownN
                      & (st_ff.pwmCnt < st_ff.brActive[i] || st_ff.brActive[i] == 8'hFF);
    end
  end
  // Register state; defaults at power-up
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Outputs
  assign bus.sdaSOut = 1'b0;
  assign bus.sdaSOe = st_ff.ackDrive;
  assign ledOn = st_ff.led;
  assign softShutdownN = st_ff.shutdownN;
  // Scale bits per channel
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gScale
      assign currentScaleSel[2*g+1:2*g] = st_ff.ctActive[g][SCALE_LSB+1:SCALE_LSB];
    end
  endgenerate
endmodule

// [hdl/led_bank_host.sv]
// Bus master that writes the LED register bank on software orders
`timescale 1ns/10ps
module led_bank_host
  import led_bank_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Bus
  led_bus_if.host bus,
  // Software port
  input wire logic [1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData
);
  // Software registers: 0 command write / data read, 1 data write / status read
  typedef enum logic [1:0] {M_IDLE = 2'h0, M_LOW = 2'h1, M_HIGH = 2'h3, M_FIN = 2'h2} mst_t;
  typedef struct packed {
    mst_t st;
    cmd_t cmd;            // Order in progress
    logic [7:0] tx;       // Byte being sent
    logic [3:0] bitIdx;   // 0..7 data, 8 ack
    logic [7:0] cnt;      // Half-bit timer
    logic scl;            // Clock level driven
    logic sda;            // Data level driven
    logic nack;           // Last ack missing
    logic [7:0] rd;       // Read data
  } host_t;
  host_t st_ff, nxt_st;
  logic sdaS, sdaP, sclS, sclP;
  line_sync u_sda (.mclk(mclk), .rstn(rstn), .din(bus.sdaLine), .dout(sdaS), .dprev(sdaP));
  line_sync u_scl (.mclk(mclk), .rstn(rstn), .din(bus.sclLine), .dout(sclS), .dprev(sclP));
  // Sequencer, each phase lasts HALF_CYC cycles so clock stays at or below 400kHz
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd = 8'h00;
    if (rdStb) begin
      nxt_st.rd = (addr == 2'h1) ? {6'h00, st_ff.nack, st_ff.st != M_IDLE} : st_ff.tx;
    end
    nxt_st.cnt = (st_ff.cnt == 8'(HALF_CYC - 1)) ? 8'h00 : st_ff.cnt + 8'h01;
    unique case (st_ff.st)
      M_IDLE: begin
        nxt_st.cnt = 8'h00;
        if (wrStb && addr == 2'h0) begin
          nxt_st.cmd = cmd_t'(wrData[1:0]);
        end else if (wrStb && addr == 2'h1) begin
          nxt_st.tx = wrData;
          nxt_st.cmd = CMD_BYTE;
        end
        if (wrStb && nxt_st.cmd != CMD_NONE) begin
          nxt_st.st = M_LOW;
          nxt_st.bitIdx = 4'h0;
          if (nxt_st.cmd == CMD_START) begin
            nxt_st.sda = 1'b0;    // Data falls while clock high
          end
        end
      end
      M_LOW: if (st_ff.cnt == 8'(HALF_CYC - 1)) begin
        if (st_ff.cmd == CMD_START) begin
          nxt_st.scl = 1'b0;
          nxt_st.st = M_FIN;
        end else if (st_ff.cmd == CMD_STOP) begin
          nxt_st.scl = 1'b0;
          nxt_st.sda = 1'b0;
          nxt_st.st = M_HIGH;
        end else begin
          // Drive next bit MSB first with clock low
          nxt_st.scl = 1'b0;
          nxt_st.sda = (st_ff.bitIdx == 4'h8) ? 1'b1 : st_ff.tx[3'(7 - st_ff.bitIdx)];
          nxt_st.st = M_HIGH;
        end
      end
      M_HIGH: if (st_ff.cnt == 8'(HALF_CYC - 1)) begin
        nxt_st.scl = 1'b1;  // Data held through high phase
        nxt_st.st = M_FIN;
      end
      default: if (st_ff.cnt == 8'(HALF_CYC - 1)) begin
        if (st_ff.cmd == CMD_STOP) begin
          nxt_st.sda = 1'b1;  // Rising data with clock high
          nxt_st.st = M_IDLE;
        end else if (st_ff.cmd == CMD_BYTE && st_ff.bitIdx == 4'h8) begin
          nxt_st.nack = sdaS;  // Software must send stop on nack
          // Park with clock low so the bank releases its acknowledge at once
          nxt_st.scl = 1'b0;
          nxt_st.st = M_IDLE;
        end else if (st_ff.cmd == CMD_BYTE) begin
          // Clock falls and next bit goes out together, no idle high phase
          nxt_st.bitIdx = st_ff.bitIdx + 4'h1;
          nxt_st.scl = 1'b0;
          nxt_st.sda = (st_ff.bitIdx == 4'h7) ? 1'b1 : st_ff.tx[3'(6 - st_ff.bitIdx)];
          nxt_st.st = M_HIGH;
        end else begin
          nxt_st.st = M_IDLE;
        end
      end
    endcase
  end
  // State register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '{st: M_IDLE, cmd: CMD_NONE, tx: 8'h00, bitIdx: 4'h0, cnt: 8'h00, scl: 1'b1, sda: 1'b1,
                 nack: 1'b0, rd: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end
  // Open-drain drive: enable only when pulling low
  assign bus.sclOut = 1'b0;
  assign bus.sclOe = ~st_ff.scl;
  assign bus.sdaMOut = 1'b0;
  assign bus.sdaMOe = ~st_ff.sda;
  assign rdData = st_ff.rd;
endmodule

// [dv/led_bus_assertions.sv]
// Concurrent checks on the two-wire bus between the LED bank and its master
`timescale 1ns/10ps
module led_bus_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Data enables and resolved lines
  input wire logic sdaMOe,
  input wire logic sdaSOe,
  input wire logic sclLine,
  input wire logic sdaLine
);
  localparam int MIN_PERIOD = 124;  // Rise to rise, less one, at 400kHz
  logic [7:0] perCnt_ff;    // Cycles since the last clock rise
  logic [3:0] pulseCnt_ff;  // Clock pulses since start or since the last ninth pulse
  logic nack_ff;            // Data high at the ninth rise
  logic sclPrev_ff;         // Clock one cycle back
  logic sdaPrev_ff;         // Data one cycle back
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Pulse counter, period counter and acknowledge capture
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      perCnt_ff <= 8'hFF;
      pulseCnt_ff <= 4'h0;
      nack_ff <= 1'b0;
      sclPrev_ff <= 1'b1;
      sdaPrev_ff <= 1'b1;
    end else begin
      sclPrev_ff <= sclLine;
      sdaPrev_ff <= sdaLine;
      if (sclLine && !sclPrev_ff) begin
        perCnt_ff <= 8'h00;
        pulseCnt_ff <= (pulseCnt_ff == 4'h9) ? 4'h1 : pulseCnt_ff + 4'h1;
        if (pulseCnt_ff == 4'h8) nack_ff <= sdaLine;
      end else if (perCnt_ff != 8'hFF) begin
        perCnt_ff <= perCnt_ff + 8'h01;
      end
      // Start restarts the bit position
      if (sclLine && sdaPrev_ff && !sdaLine) pulseCnt_ff <= 4'h0;
    end
  end
  // Bus conditions and the acknowledge pulse
  sequence s_start; sclLine && $fell(sdaLine); endsequence
  sequence s_stop; sclLine && $rose(sdaLine); endsequence
  sequence s_ninth; ##[1:130] $rose(sclLine) ##[40:130] $fell(sclLine); endsequence
  a_scl_period: assert property ($rose(sclLine) |-> perCnt_ff >= MIN_PERIOD)
    else $error("clock period below limit");
  a_dev_stable: assert property (sclLine && $past(sclLine) |-> $stable(sdaSOe))
    else $error("bank data moved while clock high");
  a_start_hold: assert property (s_start |-> !sdaLine throughout (##[1:80] $fell(sclLine)))
    else $error("start not held until clock fall");
  a_stop_release: assert property (s_stop |-> !sdaSOe [*3])
    else $error("bank holds data after stop");
  a_ack_hold: assert property ($rose(sdaSOe) |-> sdaSOe throughout s_ninth)
    else $error("acknowledge dropped within ninth pulse");
  a_ack_release: assert property (sdaSOe && $fell(sclLine) && pulseCnt_ff == 4'h9 |-> ##[1:8] !sdaSOe)
    else $error("acknowledge not released");
  a_master_free: assert property (sdaSOe && sclLine |-> !sdaMOe)
    else $error("master drives data during acknowledge");
  a_ack_slot: assert property ($rose(sdaSOe) |-> !sclLine && pulseCnt_ff == 4'h8)
    else $error("acknowledge outside its slot");
  a_nack_stop: assert property ($fell(sclLine) && pulseCnt_ff == 4'h9 && nack_ff |-> ##[1:700] s_stop)
    else $error("no stop after missing acknowledge");
endmodule

// [dv/led_driver_i2c_register_bank_tb.sv]
// Self-checking bench joining the LED bank to its bus master
`timescale 1ns/10ps
module led_driver_i2c_register_bank_tb import led_bank_pkg::*;;
  logic mclk = 1'b0;            // System clock
  logic rstn = 1'b0;            // Async reset, low active
  logic [1:0] strapSel = 2'h0;  // Strap choice
  logic [1:0] addr = 2'h0;      // Software port
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'b0;
  logic rdStb = 1'b0;
  logic [7:0] rdData;
  logic [NUM_CH-1:0] ledOn;     // Bank outputs
  logic [NUM_CH*2-1:0] currentScaleSel;
  logic softShutdownN;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] shB[NUM_CH], shC[NUM_CH], actB[NUM_CH], actC[NUM_CH];  // Bank model
  logic sdn, gdis;              // Model shutdown and force-off
  logic [7:0] dq[8];            // Data bytes of one transfer
  logic [7:0] adr;              // Bank address byte
  int cnt;                      // Duty counter
  led_bus_if busIf();
  assign busIf.adStrap = 1'b0;
  led_bank_dev led_bank_dev_inst (.mclk(mclk), .rstn(rstn), .bus(busIf), .strapSel(strapSel),
    .ledOn(ledOn), .currentScaleSel(currentScaleSel), .softShutdownN(softShutdownN));
  led_bank_host led_bank_host_inst (.mclk(mclk), .rstn(rstn), .bus(busIf), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData));
  led_bus_assertions led_bus_assertions_inst (.mclk(mclk), .rstn(rstn), .sdaMOe(busIf.sdaMOe),
    .sdaSOe(busIf.sdaSOe), .sclLine(busIf.sclLine), .sdaLine(busIf.sdaLine));
  // Clock
  always #10 mclk = ~mclk;
  // Verdict and end of run
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // One comparison
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // Strap choice to address bits
  function automatic logic [1:0] strap_bits(input logic [1:0] s);
    case (s)
      2'h0: return STRAP_GND;
      2'h1: return STRAP_VCC;
      2'h2: return STRAP_SCL;
      default: return STRAP_SDA;
    endcase
  endfunction
  // Model defaults
  task automatic mreset();
    for (int i = 0; i < NUM_CH; i++) begin
      shB[i] = RESET_BYTE;
      shC[i] = RESET_BYTE;
      actB[i] = RESET_BYTE;
      actC[i] = RESET_BYTE;
    end
    sdn = 1'b0;
    gdis = 1'b0;
  endtask
  // Model one register write
  task automatic mdl(input logic [7:0] o, input logic [7:0] d);
    if (o == OFS_SHUTDOWN) sdn = d[0];
    else if (o >= OFS_BRIGHT_FIRST && o <= OFS_BRIGHT_LAST) shB[o - OFS_BRIGHT_FIRST] = d;
    else if (o >= OFS_CTRL_FIRST && o <= OFS_CTRL_LAST) shC[o - OFS_CTRL_FIRST] = d;
    else if (o == OFS_GLOBAL) gdis = d[0];
    else if (o == OFS_UPDATE && d == MAGIC_ZERO) begin
      actB = shB;
      actC = shC;
    end else if (o == OFS_RESET && d == MAGIC_ZERO) mreset();
  endtask
  // Expected outputs against the model
  task automatic check_out();
    logic [71:0] sc;
    logic [35:0] m, e;
    sc = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      sc[2*i +: 2] = actC[i][2:1];
      m[i] = !sdn || gdis || !actC[i][0] || actB[i] == 8'h00 || actB[i] == 8'hFF;
      e[i] = sdn && !gdis && actC[i][0] && actB[i] == 8'hFF;
    end
    @(posedge mclk);
    #1;
    chk(72'(softShutdownN), 72'(sdn));
    chk(72'(currentScaleSel), sc);
    chk(72'(ledOn & m), 72'(e));
  endtask
  // Software port write
  task automatic sw_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask
  // Poll status until idle, return the missing-acknowledge bit
  task automatic wait_idle(output logic nk);
    logic [7:0] st;
    st = 8'h01;
    for (int n = 0; n < 2000 && st[0] !== 1'b0; n++) begin
      @(posedge mclk);
      addr <= 2'h1;
      rdStb <= 1'b1;
      @(posedge mclk);
      rdStb <= 1'b0;
      #1 st = rdData;
    end
    if (st[0] !== 1'b0) begin
      fail_count++;
      end_sim();
    end else nk = st[1];
  endtask
  // One byte with its acknowledge
  task automatic send(input logic [7:0] b, input logic enk);
    logic nk;
    sw_wr(2'h1, b);
    wait_idle(nk);
    chk(72'(nk), 72'(enk));
    @(posedge mclk);
    addr <= 2'h0;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    #1 chk(72'(rdData), 72'(b));
  endtask
  // Whole transfer: start, address, offset, data, stop
  task automatic xfer(input logic [7:0] a, input logic [7:0] ofs, input int n, input logic enk);
    logic nk;
    sw_wr(2'h0, 8'h01);
    wait_idle(nk);
    send(a, enk);
    if (!enk) begin
      send(ofs, 1'b0);
      for (int i = 0; i < n; i++) begin
        send(dq[i], 1'b0);
        mdl(ofs + 8'(i), dq[i]);
      end
    end
    sw_wr(2'h0, 8'h02);
    wait_idle(nk);
  endtask
  // Reset pulse
  task automatic do_reset();
    @(posedge mclk);
    rstn <= 1'b0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    mreset();
  endtask
  // Main sequence
  initial begin
    void'($urandom(88103));
    for (int s = 3; s >= 0; s--) begin
      strapSel <= 2'(s);
      do_reset();
      check_out();
      adr = {ADDR_FIXED, strap_bits(2'(s)), 1'b0};
      xfer(adr ^ 8'h02, OFS_SHUTDOWN, 0, 1'b1);
      xfer(adr | 8'h01, OFS_SHUTDOWN, 0, 1'b1);
      dq[0] = 8'h01;
      xfer(adr, OFS_SHUTDOWN, 1, 1'b0);
      check_out();
    end
    for (int i = 0; i < 8; i++) dq[i] = 8'($urandom()) | 8'h01;
    dq[0] = 8'hFF;
    dq[1] = 8'h00;
    dq[2] = 8'h01 + 8'($urandom_range(253));
    dq[3] = 8'h5A;
    xfer(adr, 8'h22, 7, 1'b0);
    check_out();
    xfer(adr, 8'h47, 4, 1'b0);
    dq[0] = MAGIC_ZERO;
    xfer(adr, OFS_UPDATE, 1, 1'b0);
    check_out();
    cnt = 0;
    repeat (256) begin
      @(posedge mclk);
      #1 cnt += int'(ledOn[35] === 1'b1);
    end
    chk(72'(cnt), 72'(actB[35]));
    for (int g = 1; g >= 0; g--) begin
      dq[0] = 8'(g);
      xfer(adr, OFS_GLOBAL, 1, 1'b0);
      check_out();
    end
    dq[0] = 8'h00;
    xfer(adr, OFS_SHUTDOWN, 1, 1'b0);
    dq[0] = 8'hFF;
    dq[1] = MAGIC_ZERO;
    dq[2] = 8'h07;
    xfer(adr, 8'h24, 3, 1'b0);
    check_out();
    dq[0] = 8'h01;
    xfer(adr, OFS_SHUTDOWN, 1, 1'b0);
    check_out();
    dq[0] = MAGIC_ZERO;
    xfer(adr, OFS_RESET, 1, 1'b0);
    check_out();
    end_sim();
  end
endmodule
